// ### dcr_map.vh
// Register map and field layout of the deserializer configuration bank.
// Assumes byte-wide registers at word indices 0 to 15 on a plain port.
`ifndef DCR_MAP_VH
`define DCR_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DCR_LINK_RATE_WIDTH_CONFIG     4'h0
`define DCR_SPREAD_ERROR_POLICY_CONFIG 4'h1
`define DCR_CHANNEL_START_TIMEOUT      4'h2
`define DCR_CHANNEL_END_TIMEOUT        4'h3
`define DCR_OUTPUT_EDGE_TEST_CONFIG    4'h4
`define DCR_BUS_ADDRESS                4'h5
`define DCR_END_FRAME_CODE             4'h6
`define DCR_VIDEO_PARITY_COUNT_LOW     4'ha
`define DCR_VIDEO_PARITY_COUNT_HIGH    4'hb
`define DCR_LINK_ERROR_FLAGS           4'hd

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCR_RST_LINK_RATE_WIDTH  8'hb5
`define DCR_RST_SPREAD_ERROR     8'h00
`define DCR_RST_START_TIMEOUT    8'ha0
`define DCR_RST_END_TIMEOUT      8'ha0
`define DCR_RST_OUTPUT_EDGE_TEST 8'h20
`define DCR_RST_BUS_ADDRESS      8'hf8
`define DCR_RST_END_FRAME_CODE   8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCR_PIXEL_CLOCK_RANGE     7:6
`define DCR_SERIAL_SPEED_RANGE    5:4
`define DCR_PARITY_ON             3
`define DCR_PARALLEL_WORD_WIDTH   2:0
`define DCR_SPREAD_MODE           7:6
`define DCR_AUTO_ERROR_CLEAR      5
`define DCR_ACTIVITY_DETECT_LEVEL 4:3
`define DCR_TIMEOUT_PRESCALE      7:4
`define DCR_TIMEOUT_COUNT         3:0
`define DCR_FRAME_SYNC_POLARITY   7
`define DCR_LINE_SYNC_POLARITY    6
`define DCR_PIXEL_CLOCK_POLARITY  5
`define DCR_STRETCHER_LONG_PULSE  3
`define DCR_LINK_TEST_ON          0
`define DCR_ADDRESS_FIELD         7:1

// Error flag bits in the flag register
`define DCR_FLAG_DES_PARITY  4
`define DCR_FLAG_DES_FRAME   3
`define DCR_FLAG_SER_PARITY  2
`define DCR_FLAG_SER_FRAME   1
`define DCR_FLAG_I2C         0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DCR_PRESCALE_ZERO_DIV 5'h10
`define DCR_COUNT_MAX         16'hffff

`endif

// ### dcr_timeout.v
// Prescaled timeout counter for the control channel.
// Assumes run and restart come from logic on the same pixel clock.
`timescale 1ns/1ps
module dcr_timeout (
  clk,
  rstn,
  run,
  restart,
  prescale,
  limit,
  expire
);
`include "dcr_map.vh"
  input  wire       clk;
  input  wire       rstn;
  input  wire       run;
  input  wire       restart;
  input  wire [3:0] prescale;
  input  wire [3:0] limit;
  output wire       expire;

  reg  [4:0] pre_q;
  reg  [3:0] ticks_q;
  reg        expire_q;
  wire [4:0] div;
  wire       tick;

  // Code zero is the longest prescale; other codes divide by their value
  assign div  = (prescale == 4'h0) ? `DCR_PRESCALE_ZERO_DIV : {1'b0, prescale};
  assign tick = (pre_q == (div - 5'h01));

  always @(posedge clk) begin
    if (!rstn || !run || restart) begin
      pre_q    <= 5'h00;
      ticks_q  <= 4'h0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (tick) begin
        pre_q <= 5'h00;
        if (ticks_q == limit) begin
          expire_q <= 1'b1;
          ticks_q  <= 4'h0;
        end else begin
          ticks_q <= ticks_q + 4'h1;
        end
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end

  assign expire = expire_q;
endmodule // dcr_timeout

// ### dcr_top.v
// Configuration register bank of the video-link deserializer, with
// control channel session timing and error count bookkeeping.
// Assumes all event inputs come from logic on the recovered pixel clock.
//
// Contract
// - Pixel clock range field, register 0 bits 7:6, resets to 10.
// - Serial rate range field, register 0 bits 5:4, resets to 11.
// - Register 0 bit 3 enables link parity, reset disabled.
// - Register 0 bits 2:0 select parallel width, reset 101.
// - Register 1 bits 7:6 select spread: off, 2 or 4 percent.
// - With auto clear set, error counts clear when a session ends.
// - With auto clear clear, reading registers 10, 11, 13 clears errors.
// - Register 1 bits 4:3 select activity detector offset, reset 00.
// - Opened session closes if controller never uses it in time.
// - Register 2 bits 7:4 prescale start timeout; zero divides by 16.
// - Start timeout expires after register 2 count plus one ticks.
// - Register 3 bits 7:4 prescale end timeout; zero divides by 16.
// - End timeout expires after register 3 count plus one ticks.
// - After first use, idle channel closes after end interval.
// - Register 4 bit 7 picks frame sync edge, reset falling.
// - Register 4 bit 6 picks line sync edge, reset falling.
// - Register 4 bit 5 picks pixel clock edge, reset rising.
// - Register 4 bit 3 makes stretcher pulse long, reset short.
// - Register 4 bit 0 enables the pseudo-random link test.
// - Register 5 bits 7:1 hold bus address, reset 1111100.
// - Register 6 bits 7:1 hold end-frame code; that frame closes.
// - Sixteen-bit video parity error count at registers 10 and 11.
// - Register 13 reports link parity, framing and I2C error flags.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module dcr_top (
  clk,
  rstn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  chan_open,
  chan_use,
  frame_valid,
  frame_code,
  video_parity_err,
  des_parity_err,
  des_frame_err,
  ser_parity_err,
  ser_frame_err,
  i2c_err,
  chan_active,
  chan_close,
  pixel_clock_range,
  serial_speed_range,
  parity_on,
  parallel_word_width,
  spread_on,
  spread_wide,
  activity_detect_level,
  frame_sync_polarity,
  line_sync_polarity,
  pixel_clock_polarity,
  stretcher_long_pulse,
  link_test_on,
  bus_address_field
);
`include "dcr_map.vh"
  input  wire       clk;
  input  wire       rstn;
  input  wire [3:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_wr;
  input  wire       reg_rd;
  output wire [7:0] reg_rdata;
  input  wire       chan_open;
  input  wire       chan_use;
  input  wire       frame_valid;
  input  wire [6:0] frame_code;
  input  wire       video_parity_err;
  input  wire       des_parity_err;
  input  wire       des_frame_err;
  input  wire       ser_parity_err;
  input  wire       ser_frame_err;
  input  wire       i2c_err;
  output wire       chan_active;
  output wire       chan_close;
  output wire [1:0] pixel_clock_range;
  output wire [1:0] serial_speed_range;
  output wire       parity_on;
  output wire [2:0] parallel_word_width;
  output wire       spread_on;
  output wire       spread_wide;
  output wire [1:0] activity_detect_level;
  output wire       frame_sync_polarity;
  output wire       line_sync_polarity;
  output wire       pixel_clock_polarity;
  output wire       stretcher_long_pulse;
  output wire       link_test_on;
  output wire [6:0] bus_address_field;

  // ----------------------------------------------------------------
  // Session states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_USE  = 3'h4;

  reg  [7:0]  link_rate_width_config_q;
  reg  [7:0]  spread_error_policy_config_q;
  reg  [7:0]  channel_start_timeout_q;
  reg  [7:0]  channel_end_timeout_q;
  reg  [7:0]  output_edge_test_config_q;
  reg  [7:0]  bus_address_q;
  reg  [7:0]  end_frame_code_q;
  reg  [15:0] parity_count_q;
  reg  [15:0] parity_count_d;
  reg  [4:0]  err_flags_q;
  reg  [4:0]  err_flags_d;
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         close_q;
  wire        auto_error_clear;
  wire        end_frame_seen;
  wire        start_expire;
  wire        end_expire;
  wire        session_end;
  wire        read_count;
  wire        read_flags;
  wire        clear_count;
  wire        clear_flags;
  wire [4:0]  err_events;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved bits are stored as written so that every register reads
  // back exactly; software keeps them at their fixed values.
  always @(posedge clk) begin
    if (!rstn) begin
      link_rate_width_config_q     <= `DCR_RST_LINK_RATE_WIDTH;
      spread_error_policy_config_q <= `DCR_RST_SPREAD_ERROR;
      channel_start_timeout_q      <= `DCR_RST_START_TIMEOUT;
      channel_end_timeout_q        <= `DCR_RST_END_TIMEOUT;
      output_edge_test_config_q    <= `DCR_RST_OUTPUT_EDGE_TEST;
      bus_address_q                <= `DCR_RST_BUS_ADDRESS;
      end_frame_code_q             <= `DCR_RST_END_FRAME_CODE;
    end else if (reg_wr) begin
      case (reg_addr)
        `DCR_LINK_RATE_WIDTH_CONFIG: begin
          link_rate_width_config_q <= reg_wdata;
        end
        `DCR_SPREAD_ERROR_POLICY_CONFIG: begin
          spread_error_policy_config_q <= reg_wdata;
        end
        `DCR_CHANNEL_START_TIMEOUT: begin
          channel_start_timeout_q <= reg_wdata;
        end
        `DCR_CHANNEL_END_TIMEOUT: begin
          channel_end_timeout_q <= reg_wdata;
        end
        `DCR_OUTPUT_EDGE_TEST_CONFIG: begin
          output_edge_test_config_q <= reg_wdata;
        end
        `DCR_BUS_ADDRESS: begin
          bus_address_q <= reg_wdata;
        end
        `DCR_END_FRAME_CODE: begin
          end_frame_code_q <= reg_wdata;
        end
        default: begin
          // Counts and flags are read only; other offsets ignore writes
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  assign pixel_clock_range     = link_rate_width_config_q[`DCR_PIXEL_CLOCK_RANGE];
  assign serial_speed_range    = link_rate_width_config_q[`DCR_SERIAL_SPEED_RANGE];
  assign parity_on             = link_rate_width_config_q[`DCR_PARITY_ON];
  assign parallel_word_width   = link_rate_width_config_q[`DCR_PARALLEL_WORD_WIDTH];
  // Low bit of the spread code switches it on; high bit picks the depth
  assign spread_on             = spread_error_policy_config_q[6];
  assign spread_wide           = spread_error_policy_config_q[7] &
                                 spread_error_policy_config_q[6];
  assign auto_error_clear      = spread_error_policy_config_q[`DCR_AUTO_ERROR_CLEAR];
  assign activity_detect_level =
    spread_error_policy_config_q[`DCR_ACTIVITY_DETECT_LEVEL];
  assign frame_sync_polarity   = output_edge_test_config_q[`DCR_FRAME_SYNC_POLARITY];
  assign line_sync_polarity    = output_edge_test_config_q[`DCR_LINE_SYNC_POLARITY];
  assign pixel_clock_polarity  = output_edge_test_config_q[`DCR_PIXEL_CLOCK_POLARITY];
  assign stretcher_long_pulse  = output_edge_test_config_q[`DCR_STRETCHER_LONG_PULSE];
  assign link_test_on          = output_edge_test_config_q[`DCR_LINK_TEST_ON];
  assign bus_address_field     = bus_address_q[`DCR_ADDRESS_FIELD];

  // ----------------------------------------------------------------
  // Control channel timeouts
  // ----------------------------------------------------------------
  // Start timer runs only while waiting for the first use
  dcr_timeout u_start_timeout (
    .clk      (clk),
    .rstn     (rstn),
    .run      (state_q[1]),
    .restart  (chan_open),
    .prescale (channel_start_timeout_q[`DCR_TIMEOUT_PRESCALE]),
    .limit    (channel_start_timeout_q[`DCR_TIMEOUT_COUNT]),
    .expire   (start_expire)
  );

  // End timer restarts on every use of the channel
  dcr_timeout u_end_timeout (
    .clk      (clk),
    .rstn     (rstn),
    .run      (state_q[2]),
    .restart  (chan_use),
    .prescale (channel_end_timeout_q[`DCR_TIMEOUT_PRESCALE]),
    .limit    (channel_end_timeout_q[`DCR_TIMEOUT_COUNT]),
    .expire   (end_expire)
  );

  assign end_frame_seen = frame_valid &&
                          (frame_code == end_frame_code_q[`DCR_ADDRESS_FIELD]);

  // ----------------------------------------------------------------
  // Session state machine
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (chan_open) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (end_frame_seen) begin
          state_d = ST_IDLE;
        end else if (start_expire) begin
          state_d = ST_IDLE;
        end else if (chan_use) begin
          state_d = ST_USE;
        end
      end
      ST_USE: begin
        if (end_frame_seen) begin
          state_d = ST_IDLE;
        end else if (end_expire && !chan_use) begin
          // A use in the expiry cycle keeps the channel open
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      close_q <= 1'b0;
    end else begin
      state_q <= state_d;
      close_q <= session_end;
    end
  end

  assign session_end = !state_q[0] && state_d[0];
  assign chan_active = !state_q[0];
  assign chan_close  = close_q;

  // ----------------------------------------------------------------
  // Error count and flags
  // ----------------------------------------------------------------
  assign read_count  = reg_rd && ((reg_addr == `DCR_VIDEO_PARITY_COUNT_LOW) ||
                                  (reg_addr == `DCR_VIDEO_PARITY_COUNT_HIGH));
  assign read_flags  = reg_rd && (reg_addr == `DCR_LINK_ERROR_FLAGS);
  assign clear_count = auto_error_clear ? session_end : read_count;
  assign clear_flags = auto_error_clear ? session_end : read_flags;

  assign err_events = {des_parity_err, des_frame_err, ser_parity_err,
                       ser_frame_err, i2c_err};

  // An error in the clearing cycle survives the clear
  always @* begin
    parity_count_d = clear_count ? 16'h0000 : parity_count_q;
    if (video_parity_err && (parity_count_d != `DCR_COUNT_MAX)) begin
      parity_count_d = parity_count_d + 16'h0001;
    end
    err_flags_d = (clear_flags ? 5'h00 : err_flags_q) | err_events;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      parity_count_q <= 16'h0000;
      err_flags_q    <= 5'h00;
    end else begin
      parity_count_q <= parity_count_d;
      err_flags_q    <= err_flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Data is captured before a clear-on-read takes effect
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `DCR_LINK_RATE_WIDTH_CONFIG: begin
          rdata_d = link_rate_width_config_q;
        end
        `DCR_SPREAD_ERROR_POLICY_CONFIG: begin
          rdata_d = spread_error_policy_config_q;
        end
        `DCR_CHANNEL_START_TIMEOUT: begin
          rdata_d = channel_start_timeout_q;
        end
        `DCR_CHANNEL_END_TIMEOUT: begin
          rdata_d = channel_end_timeout_q;
        end
        `DCR_OUTPUT_EDGE_TEST_CONFIG: begin
          rdata_d = output_edge_test_config_q;
        end
        `DCR_BUS_ADDRESS: begin
          rdata_d = bus_address_q;
        end
        `DCR_END_FRAME_CODE: begin
          rdata_d = end_frame_code_q;
        end
        `DCR_VIDEO_PARITY_COUNT_LOW: begin
          rdata_d = parity_count_q[7:0];
        end
        `DCR_VIDEO_PARITY_COUNT_HIGH: begin
          rdata_d = parity_count_q[15:8];
        end
        `DCR_LINK_ERROR_FLAGS: begin
          rdata_d = {3'h0, err_flags_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule // dcr_top

// ### dcr_top_sva.sv
// Port assertions for the deserializer configuration bank.
// Assumes it is bound onto dcr_top and every signal lives on clk.
`timescale 1ns/1ps
module dcr_top_sva (
  input wire       clk,
  input wire       rstn,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       chan_open,
  input wire       frame_valid,
  input wire [6:0] frame_code,
  input wire       chan_active,
  input wire       chan_close,
  input wire [1:0] pixel_clock_range,
  input wire [1:0] serial_speed_range,
  input wire       parity_on,
  input wire [2:0] parallel_word_width,
  input wire       spread_on,
  input wire       spread_wide,
  input wire [1:0] activity_detect_level,
  input wire       frame_sync_polarity,
  input wire       line_sync_polarity,
  input wire       pixel_clock_polarity,
  input wire       stretcher_long_pulse,
  input wire       link_test_on,
  input wire [6:0] bus_address_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Shadow of the close code, since the checker cannot read register 6
  reg [6:0] close_code_q;
  wire      wr_match = reg_wr && (reg_addr == 4'h6);
  always @(posedge clk) begin
    if (!rstn)
      close_code_q <= 7'h7f;
    else if (wr_match)
      close_code_q <= reg_wdata[7:1];
  end

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read reply");
  chk_link_rate_width_config_fields: assert property (reg_wr && reg_addr == 4'h0 |=>
    {pixel_clock_range, serial_speed_range, parity_on, parallel_word_width} == $past(reg_wdata))
    else $error("register 0 fields do not follow the write");
  chk_spread_error_policy_config_fields: assert property (reg_wr && reg_addr == 4'h1 |=>
    activity_detect_level == $past(reg_wdata[4:3]) && spread_on == $past(reg_wdata[6])
    && spread_wide == ($past(reg_wdata) >= 8'hc0))
    else $error("register 1 fields do not follow the write");
  chk_output_edge_test_config_fields: assert property (reg_wr && reg_addr == 4'h4 |=>
    {frame_sync_polarity, line_sync_polarity, pixel_clock_polarity} == $past(reg_wdata[7:5])
    && stretcher_long_pulse == $past(reg_wdata[3]) && link_test_on == $past(reg_wdata[0]))
    else $error("register 4 fields do not follow the write");
  chk_bus_address_field: assert property (reg_wr && reg_addr == 4'h5 |=>
    bus_address_field == $past(reg_wdata[7:1]))
    else $error("address field does not follow the write");
  chk_fields_hold: assert property (!reg_wr |=> $stable({pixel_clock_range, serial_speed_range,
    parity_on, parallel_word_width, spread_on, spread_wide, activity_detect_level,
    frame_sync_polarity, line_sync_polarity, pixel_clock_polarity, stretcher_long_pulse,
    link_test_on, bus_address_field}))
    else $error("field output changed without a write");
  chk_open_session: assert property (!chan_active && chan_open |=> chan_active)
    else $error("session did not open");
  chk_active_cause: assert property ($rose(chan_active) |-> $past(chan_open))
    else $error("session opened without request");
  chk_close_pulse: assert property (chan_close |->
    (!chan_active && $past(chan_active)) ##1 !chan_close)
    else $error("close pulse malformed");
  chk_end_frame: assert property (chan_active && frame_valid && frame_code == close_code_q
    |=> chan_close)
    else $error("close frame did not end the session");
  chk_idle_quiet: assert property (!chan_active |=> !chan_close)
    else $error("close pulse while idle");
endmodule // dcr_top_sva

bind dcr_top dcr_top_sva dcr_top_sva_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .chan_open, .frame_valid, .frame_code, .chan_active, .chan_close,
  .pixel_clock_range, .serial_speed_range, .parity_on, .parallel_word_width, .spread_on,
  .spread_wide, .activity_detect_level, .frame_sync_polarity, .line_sync_polarity,
  .pixel_clock_polarity, .stretcher_long_pulse, .link_test_on, .bus_address_field);

// ### dcr_host_model.sv
// Behavioural host controller on the control channel side.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`timescale 1ns/1ps
module dcr_host_model (
  input  wire       clk,
  output reg        chan_open,
  output reg        chan_use,
  output reg        frame_valid,
  output reg  [6:0] frame_code
);
  initial begin
    chan_open = 1'b0;
    chan_use = 1'b0;
    frame_valid = 1'b0;
    frame_code = 7'h00;
  end
  task open_session;
    @(posedge clk);
    chan_open <= 1'b1;
    @(posedge clk);
    chan_open <= 1'b0;
  endtask
  // Gap lets the host answer promptly or slowly
  task use_channel(input int gap);
    repeat (gap) @(posedge clk);
    chan_use <= 1'b1;
    @(posedge clk);
    chan_use <= 1'b0;
  endtask
  task send_frame(input logic [6:0] code);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_code <= code;
    @(posedge clk);
    frame_valid <= 1'b0;
    // Stale code is inverted so nothing can lean on it
    frame_code <= ~code;
  endtask
endmodule // dcr_host_model

// ### dcr_top_tb_top.sv
// Self-checking bench for the configuration bank and session timing.
// Assumes dcr_top, the host model and the bound checker are compiled.
`timescale 1ns/1ps
module dcr_top_tb_top;
  reg        clk, rstn, reg_wr, reg_rd;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        video_parity_err, des_parity_err, des_frame_err;
  reg        ser_parity_err, ser_frame_err, i2c_err;
  wire [7:0] reg_rdata;
  wire [6:0] frame_code, bus_address_field;
  wire       chan_open, chan_use, frame_valid, chan_active, chan_close;
  wire [1:0] pixel_clock_range, serial_speed_range, activity_detect_level;
  wire [2:0] parallel_word_width;
  wire       parity_on, spread_on, spread_wide, frame_sync_polarity, line_sync_polarity;
  wire       pixel_clock_polarity, stretcher_long_pulse, link_test_on;
  wire [7:0] f0 = {pixel_clock_range, serial_speed_range, parity_on, parallel_word_width};
  wire [7:0] f1 = {3'h0, spread_wide, spread_on, 1'b0, activity_detect_level};
  wire [7:0] f4 = {frame_sync_polarity, line_sync_polarity, pixel_clock_polarity, 1'b0,
                   stretcher_long_pulse, 2'h0, link_test_on};
  wire [7:0] f5 = {bus_address_field, 1'b0};
  // Reserved bits kept at their fixed values
  logic [7:0] wtab [0:13] = '{8'h4a, 8'h68, 8'h53, 8'h12, 8'hc9, 8'h56, 8'h55,
                              8'h35, 8'hb0, 8'h0c, 8'hf1, 8'h21, 8'haa, 8'hab};
  int bad_count, total_checks;

  dcr_top dcr_top_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chan_open, .chan_use, .frame_valid, .frame_code, .video_parity_err,
    .des_parity_err, .des_frame_err, .ser_parity_err,
    .ser_frame_err, .i2c_err, .chan_active, .chan_close,
    .pixel_clock_range, .serial_speed_range, .parity_on, .parallel_word_width, .spread_on,
    .spread_wide, .activity_detect_level, .frame_sync_polarity, .line_sync_polarity,
    .pixel_clock_polarity, .stretcher_long_pulse, .link_test_on, .bus_address_field);
  dcr_host_model host (.clk, .chan_open, .chan_use, .frame_valid, .frame_code);

  always #2.5 clk = ~clk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("read of reg %0d", a), e, reg_rdata);
  endtask
  task rfield(input logic [3:0] a, input logic [7:0] v);
    rchk(a, v);
    case (a)
      4'h0: chk("link_rate_width_config outputs", v, f0);
      4'h1: chk("spread_error_policy_config outputs", {3'h0, &v[7:6], v[6], 1'b0, v[4:3]}, f1);
      4'h4: chk("output_edge_test_config outputs", v & 8'he9, f4);
      4'h5: chk("bus_address outputs", v & 8'hfe, f5);
      default: ;
    endcase
  endtask
  task pulse_err(input logic [5:0] m);
    @(posedge clk);
    {video_parity_err, des_parity_err, des_frame_err,
     ser_parity_err, ser_frame_err, i2c_err} <= m;
    @(posedge clk);
    {video_parity_err, des_parity_err, des_frame_err,
     ser_parity_err, ser_frame_err, i2c_err} <= 6'h00;
  endtask
  task wait_close(input int lo, input int hi);
    int n;
    n = 0;
    // Step off the edge so a pulse launched there is not missed
    #1;
    while (chan_close !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > hi + 20) begin
        bad_count++;
        $display("MISMATCH close pulse expected 1 seen 0");
        report_and_stop;
      end
    end
    chk("close delay in window", 8'h01, {7'h00, n >= lo && n <= hi});
  endtask

  task t_reset_values;
    rfield(4'h0, 8'hb5);
    rfield(4'h1, 8'h00);
    rfield(4'h2, 8'ha0);
    rfield(4'h3, 8'ha0);
    rfield(4'h4, 8'h20);
    rfield(4'h5, 8'hf8);
    rfield(4'h6, 8'hff);
  endtask
  task t_readback;
    int p, i;
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 7; i++)
        wr(i[3:0], wtab[p * 7 + i]);
      for (i = 0; i < 7; i++)
        rfield(i[3:0], wtab[p * 7 + i]);
    end
    wr(4'h7, 8'hff);
    rchk(4'h7, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(4'h1, {i[1:0], 6'h00});
      rfield(4'h1, {i[1:0], 6'h00});
    end
  endtask
  task t_timeouts;
    wr(4'h2, 8'h21);
    host.open_session;
    wait_close(4, 8);
    wr(4'h2, 8'h00);
    host.open_session;
    wait_close(16, 20);
    wr(4'h2, 8'hff);
    wr(4'h3, 8'h31);
    host.open_session;
    host.use_channel(3);
    wait_close(6, 10);
  endtask
  task t_end_frame;
    wr(4'h3, 8'hff);
    wr(4'h6, 8'h55);
    host.send_frame(7'h2a);
    #1;
    chk("idle after stray frame", 8'h00, {7'h00, chan_active});
    host.open_session;
    host.use_channel(0);
    host.send_frame(7'h7f);
    host.send_frame(7'h2a);
    wait_close(0, 0);
  endtask
  task t_errors;
    int i;
    wr(4'h1, 8'h00);
    repeat (257) pulse_err(6'h20);
    rchk(4'hb, 8'h01);
    rchk(4'ha, 8'h00);
    repeat (3) pulse_err(6'h20);
    rchk(4'ha, 8'h03);
    for (i = 0; i < 5; i++) begin
      pulse_err(6'h01 << i);
      rchk(4'hd, 8'h01 << i);
      rchk(4'hd, 8'h00);
    end
    wr(4'h1, 8'h20);
    repeat (2) pulse_err(6'h21);
    rchk(4'ha, 8'h02);
    rchk(4'ha, 8'h02);
    rchk(4'hd, 8'h01);
    host.open_session;
    host.use_channel(1);
    host.send_frame(7'h2a);
    wait_close(0, 0);
    rchk(4'ha, 8'h00);
    rchk(4'hd, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {video_parity_err, des_parity_err, des_frame_err,
     ser_parity_err, ser_frame_err, i2c_err} = 6'h00;
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values;
    t_readback;
    // Second reset in mid-run must bring every default back
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset_values;
    t_timeouts;
    t_end_frame;
    t_errors;
    report_and_stop;
  end
endmodule // dcr_top_tb_top
